// ---- src/fpm_debounce.sv ----
// Pin synchroniser and debouncer for the knob and strap inputs
`timescale 1ns/1ps
`include "fpm_map.svh"
module fpm_debounce #(
  parameter int W         = 4,
  parameter int DB_CYCLES = `FPM_DB_NS / `FPM_CLK_NS
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  // Pins in, clean levels out
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);
  if (W < 1 || DB_CYCLES < 1 || DB_CYCLES >= (1 << `FPM_CNT_W)) begin
    $error("fpm_debounce: unsupported parameters");
  end

  typedef struct packed {
    logic [W-1:0]                 s1;
    logic [W-1:0]                 s2;
    logic [W-1:0]                 s3;
    logic [W-1:0]                 lvl;
    logic [W-1:0][`FPM_CNT_W-1:0] cnt;
  } fpm_db_st_t;

  fpm_db_st_t r;
  fpm_db_st_t n;

  always_comb begin
    n    = r;
    n.s1 = pin_in;
    n.s2 = r.s1;
    n.s3 = r.s2;
    for (int i = 0; i < W; i++) begin
      // Count how long stage two and three agree on a new level
      if (r.s2[i] != r.s3[i] || r.s3[i] == r.lvl[i]) begin
        n.cnt[i] = '0;
      end else if (r.cnt[i] == `FPM_CNT_W'(DB_CYCLES - 1)) begin
        n.lvl[i] = r.s3[i]; // [RULE_17]
        n.cnt[i] = '0;
      end else begin
        n.cnt[i] = r.cnt[i] + `FPM_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  assign level_out = r.lvl;
endmodule

// ---- src/fpm_map.svh ----
// Register map, codes and timing constants of the front-panel menu block
// Notes on behaviour
// RULE_01: In normal operation a press longer than one second opens the menu.
// RULE_02: Scroll: cursor line one, knob picks parameter, line two its value.
// RULE_03: Scroll mode: short press enters edit mode, cursor on line two.
// RULE_04: Edit: knob steps a candidate shown on line two, not yet applied.
// RULE_05: Edit: short press commits candidate, back to scroll on line one.
// RULE_06: Edit: long press drops candidate, keeps old value, back to scroll.
// RULE_07: Scroll mode: long press closes the menu, normal operation resumes.
// RULE_08: Menu active: analog outputs hold their last value.
// RULE_09: Menu active: serial measurement output stays idle.
// RULE_10: Knob held at power-up locks controls: no menu, no remote changes.
// RULE_11: Lock keeps normal operation until standby or power loss.
// RULE_12: Backlight codes 1 off, 2 dark, 3 medium, 4 bright drive intensity.
// RULE_13: Add-on module shows field setting 0 and cannot change it.
// RULE_14: Main module field code 1 is off, code 2 is twenty percent.
// RULE_15: Field codes 3, 4, 5 give 40, 60, 80 percent; 6 gives full.
// RULE_16: Output swing offers plus-minus 9 V and plus-minus 4.5 V.
// RULE_17: Press timed to release; exactly one second is short; debounced.
`ifndef FPM_MAP_SVH
`define FPM_MAP_SVH

// Register byte offsets
`define FPM_ADDR_CTRL     8'h00
`define FPM_ADDR_STATUS   8'h04
`define FPM_ADDR_SETTINGS 8'h08
`define FPM_AXI_AW        8

// Control and status fields
`define FPM_CTRL_STBY     0
`define FPM_ST_STATE_LSB  0
`define FPM_ST_CURSOR     2
`define FPM_ST_LOCKED     3
`define FPM_ST_MAIN       4
`define FPM_ST_PIDX_LSB   8
`define FPM_ST_CAND_LSB   12
`define FPM_SET_BL_LSB    0
`define FPM_SET_FS_LSB    4
`define FPM_SET_SW_LSB    8

// Bus responses
`define FPM_RESP_OKAY     2'h0
`define FPM_RESP_SLVERR   2'h2

// Parameters and setting codes
`define FPM_NPAR          3
`define FPM_PIDX_W        2
`define FPM_SET_W         3
`define FPM_P_BL          0
`define FPM_P_FS          1
`define FPM_P_SW          2
`define FPM_PIDX_LAST     2'h2
`define FPM_BL_MIN        3'h1
`define FPM_BL_MAX        3'h4
`define FPM_BL_RST        3'h3
`define FPM_FS_ADDON      3'h0
`define FPM_FS_MIN        3'h1
`define FPM_FS_MAX        3'h6
`define FPM_SW_9V         3'h1
`define FPM_SW_4V5        3'h2

// Field strength in percent of nominal
`define FPM_PCT_OFF       7'h00
`define FPM_PCT_20        7'h14
`define FPM_PCT_40        7'h28
`define FPM_PCT_60        7'h3c
`define FPM_PCT_80        7'h50
`define FPM_PCT_100       7'h64

// Timing
`define FPM_CLK_NS        25
`define FPM_LONG_NS       1000000000
`define FPM_DB_NS         5000000
`define FPM_BOOT_NS       500000000
`define FPM_CNT_W         26
`define FPM_ANA_W         16
`define FPM_SER_W         8

`endif

// ---- src/fpm_pkg.sv ----
// Types of the front-panel menu block
package fpm_pkg;
`include "fpm_map.svh"

  typedef enum logic [1:0] {
    FPM_BOOT   = 2'b00,
    FPM_NORMAL = 2'b01,
    FPM_SCROLL = 2'b10,
    FPM_EDIT   = 2'b11
  } fpm_state_t;

  typedef logic [`FPM_NPAR-1:0][`FPM_SET_W-1:0] fpm_set_t;

  typedef struct packed {
    fpm_state_t                state;
    logic                      locked;
    logic                      main_mod;
    logic                      stby;
    logic [`FPM_CNT_W-1:0]     boot_cnt;
    fpm_set_t                  settings;
    logic [`FPM_SET_W-1:0]     cand;
    logic [`FPM_PIDX_W-1:0]    pidx;
    logic                      a_prev;
    logic [1:0]                bl_out;
    logic                      fs_en;
    logic [6:0]                fs_pct;
    logic                      sw_half;
    logic                      cursor;
    logic [`FPM_SET_W-1:0]     disp_val;
    logic [`FPM_ANA_W-1:0]     ana;
    logic                      txv;
    logic [`FPM_SER_W-1:0]     txd;
    logic                      awv;
    logic [`FPM_AXI_AW-1:0]    awa;
    logic                      wv;
    logic [31:0]               wd;
    logic [3:0]                ws;
    logic                      bv;
    logic [1:0]                br;
    logic                      rv;
    logic [31:0]               rd;
    logic [1:0]                rr;
  } fpm_top_st_t;
endpackage

// ---- src/fpm_press.sv ----
// Knob press timer that classifies each press as short or long
`timescale 1ns/1ps
`include "fpm_map.svh"
module fpm_press #(
  parameter int LONG_CYCLES = `FPM_LONG_NS / `FPM_CLK_NS
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  // Debounced push level
  input  wire logic push,
  // Press events, one cycle each
  output logic      short_ev,
  output logic      long_ev
);
  if (LONG_CYCLES < 1 || LONG_CYCLES + 1 >= (1 << `FPM_CNT_W)) begin
    $error("fpm_press: unsupported LONG_CYCLES");
  end

  typedef struct packed {
    logic                  prev;
    logic [`FPM_CNT_W-1:0] cnt;
    logic                  sh;
    logic                  lg;
  } fpm_pr_st_t;

  fpm_pr_st_t r;
  fpm_pr_st_t n;

  always_comb begin
    n      = r;
    n.prev = push;
    n.sh   = 1'b0;
    n.lg   = 1'b0;
    if (push) begin
      if (!r.prev) begin
        n.cnt = `FPM_CNT_W'(1);
      end else if (r.cnt <= `FPM_CNT_W'(LONG_CYCLES)) begin
        n.cnt = r.cnt + `FPM_CNT_W'(1);
      end
    end else if (r.prev) begin
      // Judged at release; exactly the threshold counts as short
      n.lg = (r.cnt > `FPM_CNT_W'(LONG_CYCLES)); // [RULE_17]
      n.sh = !n.lg; // [RULE_17]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  assign short_ev = r.sh;
  assign long_ev  = r.lg;
endmodule

// ---- src/fpm_top.sv ----
// Front-panel menu controller with knob input and AXI4-Lite registers
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "fpm_map.svh"
module fpm_top #(
  parameter int LONG_CYCLES = `FPM_LONG_NS / `FPM_CLK_NS,
  parameter int DB_CYCLES   = `FPM_DB_NS / `FPM_CLK_NS,
  parameter int BOOT_CYCLES = `FPM_BOOT_NS / `FPM_CLK_NS
) (
  // Clock, reset, enable
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   ce,
  // Knob and module strap pins
  input  wire logic                   knob_a,
  input  wire logic                   knob_b,
  input  wire logic                   knob_push,
  input  wire logic                   main_strap,
  // Display state
  output logic                        disp_menu,
  output logic                        disp_lock_msg,
  output logic                        disp_cursor,
  output logic [`FPM_PIDX_W-1:0]      disp_param,
  output logic [`FPM_SET_W-1:0]       disp_value,
  // Backlight, field and swing controls
  output logic [1:0]                  backlight_level,
  output logic                        field_enable,
  output logic [6:0]                  field_pct,
  output logic                        swing_half,
  // Analog output path
  input  wire logic                   ana_in_valid,
  input  wire logic [`FPM_ANA_W-1:0]  ana_in,
  output logic [`FPM_ANA_W-1:0]       ana_out,
  // Serial measurement path
  input  wire logic                   meas_valid,
  input  wire logic [`FPM_SER_W-1:0]  meas_data,
  output logic                        meas_ready,
  output logic                        ser_tx_valid,
  output logic [`FPM_SER_W-1:0]       ser_tx_data,
  input  wire logic                   ser_tx_ready,
  // AXI4-Lite slave
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [`FPM_AXI_AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]             s_axi_awprot,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  output logic [1:0]                  s_axi_bresp,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  input  wire logic [`FPM_AXI_AW-1:0] s_axi_araddr,
  input  wire logic [2:0]             s_axi_arprot,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp
);
  if (BOOT_CYCLES < 1 || BOOT_CYCLES >= (1 << `FPM_CNT_W)) begin
    $error("fpm_top: unsupported BOOT_CYCLES");
  end

  logic [3:0] pins_clean;
  logic       a_db;
  logic       b_db;
  logic       push_db;
  logic       strap_db;
  logic       short_ev;
  logic       long_ev;

  fpm_debounce #(
    .W         (4),
    .DB_CYCLES (DB_CYCLES)
  ) u_db (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .pin_in    ({main_strap, knob_push, knob_b, knob_a}),
    .level_out (pins_clean)
  );

  assign a_db     = pins_clean[0];
  assign b_db     = pins_clean[1];
  assign push_db  = pins_clean[2];
  assign strap_db = pins_clean[3];

  fpm_press #(
    .LONG_CYCLES (LONG_CYCLES)
  ) u_press (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .push     (push_db),
    .short_ev (short_ev),
    .long_ev  (long_ev)
  );

  // Code limits of each parameter
  function automatic logic [`FPM_SET_W-1:0] lo_of(
    input logic [`FPM_PIDX_W-1:0] p,
    input logic                   main_m
  );
    if (p == `FPM_PIDX_W'(`FPM_P_BL)) begin
      lo_of = `FPM_BL_MIN;
    end else if (p == `FPM_PIDX_W'(`FPM_P_FS)) begin
      lo_of = main_m ? `FPM_FS_MIN : `FPM_FS_ADDON;
    end else begin
      lo_of = `FPM_SW_9V;
    end
  endfunction

  function automatic logic [`FPM_SET_W-1:0] hi_of(
    input logic [`FPM_PIDX_W-1:0] p,
    input logic                   main_m
  );
    if (p == `FPM_PIDX_W'(`FPM_P_BL)) begin
      hi_of = `FPM_BL_MAX;
    end else if (p == `FPM_PIDX_W'(`FPM_P_FS)) begin
      hi_of = main_m ? `FPM_FS_MAX : `FPM_FS_ADDON;
    end else begin
      hi_of = `FPM_SW_4V5;
    end
  endfunction

  // Field code to percent of nominal
  function automatic logic [6:0] pct_of(input logic [`FPM_SET_W-1:0] c);
    case (c)
      3'h2:    pct_of = `FPM_PCT_20;
      3'h3:    pct_of = `FPM_PCT_40;
      3'h4:    pct_of = `FPM_PCT_60;
      3'h5:    pct_of = `FPM_PCT_80;
      3'h6:    pct_of = `FPM_PCT_100;
      default: pct_of = `FPM_PCT_OFF;
    endcase
  endfunction

  localparam fpm_pkg::fpm_top_st_t RST = '{
    state:    fpm_pkg::FPM_BOOT,
    settings: {`FPM_SW_9V, `FPM_FS_MAX, `FPM_BL_RST},
    default:  '0
  };

  fpm_pkg::fpm_top_st_t r;
  fpm_pkg::fpm_top_st_t n;

  logic                      rot_up;
  logic                      rot_dn;
  logic                      wr_go;
  logic [`FPM_SET_W-1:0]     lo;
  logic [`FPM_SET_W-1:0]     hi;
  logic [`FPM_SET_W-1:0]     v_bl;
  logic [`FPM_SET_W-1:0]     v_fs;
  logic [`FPM_SET_W-1:0]     v_sw;
  logic [`FPM_SET_W-1:0]     bl_m1;

  assign rot_up = a_db && !r.a_prev && !b_db;
  assign rot_dn = a_db && !r.a_prev && b_db;
  assign wr_go  = r.awv && r.wv && !r.bv;
  assign v_bl   = r.wd[`FPM_SET_BL_LSB +: `FPM_SET_W];
  assign v_fs   = r.wd[`FPM_SET_FS_LSB +: `FPM_SET_W];
  assign v_sw   = r.wd[`FPM_SET_SW_LSB +: `FPM_SET_W];

  // Handshakes close only on enabled edges
  assign s_axi_awready = ce && !r.awv;
  assign s_axi_wready  = ce && !r.wv;
  assign s_axi_arready = ce && !r.rv;

  always_comb begin
    n        = r;
    n.a_prev = a_db;
    lo       = lo_of(r.pidx, r.main_mod);
    hi       = hi_of(r.pidx, r.main_mod);

    // Bus handshakes
    if (r.bv && s_axi_bready) begin
      n.bv = 1'b0;
    end
    if (r.rv && s_axi_rready) begin
      n.rv = 1'b0;
    end
    if (s_axi_awvalid && !r.awv) begin
      n.awv = 1'b1;
      n.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.wv) begin
      n.wv = 1'b1;
      n.wd = s_axi_wdata;
      n.ws = s_axi_wstrb;
    end

    // Menu state machine
    case (r.state)
      fpm_pkg::FPM_BOOT: begin
        n.boot_cnt = r.boot_cnt + `FPM_CNT_W'(1);
        if (push_db) begin
          n.locked = 1'b1; // [RULE_10]
        end
        if (r.boot_cnt == `FPM_CNT_W'(BOOT_CYCLES - 1)) begin
          n.state    = fpm_pkg::FPM_NORMAL;
          n.main_mod = strap_db;
          if (!strap_db) begin
            n.settings[`FPM_P_FS] = `FPM_FS_ADDON; // [RULE_13]
          end
        end
      end
      fpm_pkg::FPM_NORMAL: begin
        if (long_ev && !r.locked && !r.stby) begin
          n.state = fpm_pkg::FPM_SCROLL; // [RULE_01] [RULE_10] [RULE_11]
          n.pidx  = '0;
        end
      end
      fpm_pkg::FPM_SCROLL: begin
        if (long_ev) begin
          n.state = fpm_pkg::FPM_NORMAL; // [RULE_07]
        end else if (short_ev) begin
          n.state = fpm_pkg::FPM_EDIT; // [RULE_03]
          n.cand  = r.settings[r.pidx];
        end else if (rot_up) begin
          n.pidx = (r.pidx == `FPM_PIDX_LAST) ? '0 // [RULE_02]
                 : r.pidx + `FPM_PIDX_W'(1);
        end else if (rot_dn) begin
          n.pidx = (r.pidx == '0) ? `FPM_PIDX_LAST // [RULE_02]
                 : r.pidx - `FPM_PIDX_W'(1);
        end
      end
      fpm_pkg::FPM_EDIT: begin
        if (long_ev) begin
          n.state = fpm_pkg::FPM_SCROLL; // [RULE_06]
        end else if (short_ev) begin
          n.state             = fpm_pkg::FPM_SCROLL; // [RULE_05]
          n.settings[r.pidx]  = r.cand;
        end else if (rot_up) begin
          n.cand = (r.cand >= hi) ? lo : r.cand + 3'h1; // [RULE_04]
        end else if (rot_dn) begin
          n.cand = (r.cand <= lo) ? hi : r.cand - 3'h1; // [RULE_04]
        end
      end
      default: n.state = fpm_pkg::FPM_NORMAL;
    endcase

    // Standby clears the lock and closes the menu
    if (r.stby && r.state != fpm_pkg::FPM_BOOT) begin
      n.locked = 1'b0; // [RULE_11]
      n.state  = fpm_pkg::FPM_NORMAL;
    end

    // Register writes
    if (wr_go) begin
      n.awv = 1'b0;
      n.wv  = 1'b0;
      n.bv  = 1'b1;
      n.br  = `FPM_RESP_OKAY;
      if (r.awa == `FPM_ADDR_CTRL) begin
        if (r.ws[0]) begin
          n.stby = r.wd[`FPM_CTRL_STBY];
        end
      end else if (r.awa == `FPM_ADDR_SETTINGS) begin
        if (r.locked) begin
          n.br = `FPM_RESP_SLVERR; // [RULE_10]
        end else begin
          if (r.ws[0] && v_bl >= `FPM_BL_MIN && v_bl <= `FPM_BL_MAX) begin
            n.settings[`FPM_P_BL] = v_bl;
          end
          if (r.ws[0] && r.main_mod && v_fs >= `FPM_FS_MIN
              && v_fs <= `FPM_FS_MAX) begin
            n.settings[`FPM_P_FS] = v_fs; // [RULE_13]
          end
          if (r.ws[1] && v_sw >= `FPM_SW_9V && v_sw <= `FPM_SW_4V5) begin
            n.settings[`FPM_P_SW] = v_sw;
          end
        end
      end else if (r.awa != `FPM_ADDR_STATUS) begin
        n.br = `FPM_RESP_SLVERR;
      end
    end

    // Register reads
    if (s_axi_arvalid && !r.rv) begin
      n.rv = 1'b1;
      n.rd = '0;
      n.rr = `FPM_RESP_OKAY;
      if (s_axi_araddr == `FPM_ADDR_CTRL) begin
        n.rd[`FPM_CTRL_STBY] = r.stby;
      end else if (s_axi_araddr == `FPM_ADDR_STATUS) begin
        n.rd[`FPM_ST_STATE_LSB +: 2]          = r.state;
        n.rd[`FPM_ST_CURSOR]                  = r.cursor;
        n.rd[`FPM_ST_LOCKED]                  = r.locked;
        n.rd[`FPM_ST_MAIN]                    = r.main_mod;
        n.rd[`FPM_ST_PIDX_LSB +: `FPM_PIDX_W] = r.pidx;
        n.rd[`FPM_ST_CAND_LSB +: `FPM_SET_W]  = r.cand;
      end else if (s_axi_araddr == `FPM_ADDR_SETTINGS) begin
        n.rd[`FPM_SET_BL_LSB +: `FPM_SET_W] = r.settings[`FPM_P_BL];
        n.rd[`FPM_SET_FS_LSB +: `FPM_SET_W] = r.settings[`FPM_P_FS];
        n.rd[`FPM_SET_SW_LSB +: `FPM_SET_W] = r.settings[`FPM_P_SW];
      end else begin
        n.rr = `FPM_RESP_SLVERR;
      end
    end

    // Registered display and control outputs
    n.cursor   = (n.state == fpm_pkg::FPM_EDIT); // [RULE_02] [RULE_03]
    n.disp_val = (n.state == fpm_pkg::FPM_EDIT) ? n.cand // [RULE_04]
               : n.settings[n.pidx]; // [RULE_02]
    bl_m1      = n.settings[`FPM_P_BL] - `FPM_BL_MIN;
    n.bl_out   = bl_m1[1:0]; // [RULE_12]
    n.fs_en    = n.main_mod // [RULE_14]
                 && n.settings[`FPM_P_FS] > `FPM_FS_MIN;
    n.fs_pct   = n.main_mod ? pct_of(n.settings[`FPM_P_FS]) // [RULE_15]
               : `FPM_PCT_OFF;
    n.sw_half  = (n.settings[`FPM_P_SW] == `FPM_SW_4V5); // [RULE_16]

    // Analog outputs update only in normal operation
    if (r.state == fpm_pkg::FPM_NORMAL && ana_in_valid) begin
      n.ana = ana_in; // [RULE_08]
    end

    // Serial output idles while the menu is open
    if (r.state != fpm_pkg::FPM_NORMAL) begin
      n.txv = 1'b0; // [RULE_09]
    end else begin
      if (r.txv && ser_tx_ready) begin
        n.txv = 1'b0;
      end
      if (meas_valid && (!r.txv || ser_tx_ready)) begin
        n.txv = 1'b1;
        n.txd = meas_data;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= RST;
    end else if (ce) begin
      r <= n;
    end
  end

  // Menu-time samples are dropped rather than queued
  assign meas_ready = ce && ((r.state != fpm_pkg::FPM_NORMAL) // [RULE_09]
                    || !r.txv || ser_tx_ready);

  assign disp_menu       = r.state == fpm_pkg::FPM_SCROLL
                        || r.state == fpm_pkg::FPM_EDIT;
  assign disp_lock_msg   = r.locked; // [RULE_10]
  assign disp_cursor     = r.cursor;
  assign disp_param      = r.pidx;
  assign disp_value      = r.disp_val;
  assign backlight_level = r.bl_out;
  assign field_enable    = r.fs_en;
  assign field_pct       = r.fs_pct;
  assign swing_half      = r.sw_half;
  assign ana_out         = r.ana;
  assign ser_tx_valid    = r.txv && ce;
  assign ser_tx_data     = r.txd;
  assign s_axi_bvalid    = r.bv && ce;
  assign s_axi_bresp     = r.br;
  assign s_axi_rvalid    = r.rv && ce;
  assign s_axi_rdata     = r.rd;
  assign s_axi_rresp     = r.rr;
endmodule

// ---- verif/fpm_knob_model.sv ----
// Operator model turning and pushing the knob
`timescale 1ns/1ps
module fpm_knob_model (
  // Clock
  input  wire logic aclk,
  // Knob pins
  output logic      knob_a,
  output logic      knob_b,
  output logic      knob_push
);
  initial begin
    knob_a = 1'b0;
    knob_b = 1'b0;
    knob_push = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic set_push(input bit v);
    knob_push <= v;
  endtask
  // Push held n cycles, then time for the event to settle
  task automatic press(input int n);
    knob_push <= 1'b1;
    wait_n(n);
    knob_push <= 1'b0;
    wait_n(16);
  endtask
  // One detent; b level set first picks the direction
  task automatic turn(input bit up);
    knob_b <= ~up;
    wait_n(8);
    knob_a <= 1'b1;
    wait_n(8);
    knob_a <= 1'b0;
    wait_n(8);
  endtask
endmodule

// ---- verif/fpm_top_props.sv ----
// Checker of the menu, display and output hold behaviour
`timescale 1ns/1ps
`include "fpm_map.svh"
module fpm_top_props (
  // Clock and reset
  input wire logic                    aclk,
  input wire logic                    aresetn,
  // Watched outputs
  input wire logic                    disp_menu,
  input wire logic                    disp_lock_msg,
  input wire logic                    disp_cursor,
  input wire logic [`FPM_PIDX_W-1:0]  disp_param,
  input wire logic                    field_enable,
  input wire logic [6:0]              field_pct,
  input wire logic [`FPM_ANA_W-1:0]   ana_out,
  input wire logic                    ser_tx_valid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_ANA_HOLD: assert property (
    disp_menu && $past(disp_menu) |-> $stable(ana_out))
    else $error("analog output moved while menu open");
  AST_SER_IDLE: assert property (
    disp_menu && $past(disp_menu) |-> !ser_tx_valid)
    else $error("serial output busy while menu open");
  AST_MENU_OPEN: assert property (
    $rose(disp_menu) |-> !disp_cursor && disp_param == 2'h0)
    else $error("menu opened outside scroll on first parameter");
  AST_CURSOR_MENU: assert property (
    disp_cursor |-> disp_menu)
    else $error("cursor on line two with menu closed");
  AST_EDIT_PARAM: assert property (
    disp_cursor && $past(disp_cursor) |-> $stable(disp_param))
    else $error("parameter changed during edit");
  AST_LOCK_NOMENU: assert property (
    disp_lock_msg |-> !disp_menu)
    else $error("menu open while controls locked");
  AST_FIELD_EN: assert property (
    field_enable == (field_pct != 7'h00))
    else $error("field enable disagrees with field percent");
  AST_FIELD_PCT: assert property (
    field_pct inside {7'h00, 7'h14, 7'h28, 7'h3c, 7'h50, 7'h64})
    else $error("field percent off the step table");
  cover property ($rose(disp_menu));
  cover property ($fell(disp_cursor) && disp_menu);
  cover property ($rose(disp_lock_msg));
endmodule

bind fpm_top fpm_top_props i_props (.aclk, .aresetn, .disp_menu,
  .disp_lock_msg, .disp_cursor, .disp_param, .field_enable, .field_pct,
  .ana_out, .ser_tx_valid);

// ---- verif/fpm_top_tb.sv ----
// Self-checking bench of the front-panel menu controller
`timescale 1ns/1ps
`include "fpm_map.svh"
module fpm_top_tb;
  logic aclk, aresetn, main_strap, knob_a, knob_b, knob_push;
  logic ce = 1'b1;
  logic disp_menu, disp_lock_msg, disp_cursor, field_enable, swing_half;
  logic [1:0] disp_param, backlight_level, s_axi_bresp, s_axi_rresp;
  logic [2:0] disp_value;
  logic [6:0] field_pct;
  logic [2:0] s_axi_awprot = 3'h0;
  logic [2:0] s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic ana_in_valid, meas_valid, meas_ready, ser_tx_valid, ser_tx_ready;
  logic [15:0] ana_in, ana_out;
  logic [7:0] meas_data, ser_tx_data, s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, v;
  logic [31:0] rnd = 32'h17687;
  bit ce_rnd;
  logic [1:0] r;
  logic [2:0] b, f, s;
  int n_errors, tests_run, cyc;

  fpm_top #(.LONG_CYCLES(20), .DB_CYCLES(2), .BOOT_CYCLES(10)) i_dut (.*);
  fpm_knob_model i_knob (.aclk, .knob_a, .knob_b, .knob_push);

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  function automatic logic [31:0] rand32();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction
  function automatic logic [6:0] exp_pct(input logic [2:0] c);
    return ({4'h0, c} - 7'h01) * 7'h14;
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] wd);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= wd;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axr(input logic [7:0] a);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic do_reset(input bit push, input bit strap);
    aresetn <= 1'b0;
    main_strap <= strap;
    i_knob.set_push(push);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (40) @(posedge aclk);
    i_knob.set_push(1'b0);
    repeat (20) @(posedge aclk);
  endtask
  // Random sample and measurement traffic, randomly stalled serial sink
  always @(posedge aclk) begin
    ana_in <= 16'(rand32());
    meas_data <= 8'(rnd >> 16);
    ser_tx_ready <= rnd[3];
    ana_in_valid <= rnd[7];
    meas_valid <= rnd[9];
    ce <= !ce_rnd || rnd[12:11] != 2'h0;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    {aresetn, main_strap, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 0;
    s_axi_wdata = '0;
    @(posedge aclk);
    do_reset(1'b0, 1'b1);
    axr(`FPM_ADDR_STATUS);
    chk("status", d[4:0], 5'h11);
    axr(`FPM_ADDR_SETTINGS);
    chk("settings", d[10:0], 11'h163);
    axr(8'h0c);
    chk("unmapped", r, `FPM_RESP_SLVERR);
    ce_rnd <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 32'h0 : (i == 1) ? 32'h153 : {16'h0, ana_in};
      b = 3'(v % 4) + 3'h1;
      f = 3'((v >> 4) % 6) + 3'h1;
      s = 3'((v >> 8) % 2) + 3'h1;
      axw(`FPM_ADDR_SETTINGS, {21'h0, s, 1'b0, f, 1'b0, b});
      repeat (2) @(posedge aclk);
      chk("backlight", backlight_level, b - 3'h1);
      chk("field_pct", field_pct, exp_pct(f));
      chk("field_en", field_enable, f > 3'h1);
      chk("swing", swing_half, s == 3'h2);
    end
    ce_rnd <= 1'b0;
    axw(`FPM_ADDR_SETTINGS, 32'h163);
    i_knob.press(30);
    chk("menu", {disp_menu, disp_cursor, disp_param}, 4'h8);
    i_knob.turn(1'b1);
    i_knob.turn(1'b1);
    chk("scroll", {disp_param, disp_value}, 5'h11);
    i_knob.press(10);
    chk("edit", disp_cursor, 1'b1);
    i_knob.turn(1'b1);
    chk("cand", {disp_value, swing_half}, 4'h4);
    i_knob.press(10);
    chk("commit", {disp_cursor, swing_half}, 2'h1);
    i_knob.press(10);
    i_knob.turn(1'b0);
    i_knob.press(30);
    chk("discard", {disp_cursor, swing_half, disp_value}, 5'h0a);
    i_knob.press(30);
    chk("close", disp_menu, 1'b0);
    i_knob.press(20);
    chk("one_sec", disp_menu, 1'b0);
    do_reset(1'b1, 1'b0);
    chk("lock_msg", disp_lock_msg, 1'b1);
    axw(`FPM_ADDR_SETTINGS, 32'h121);
    chk("remote", r, `FPM_RESP_SLVERR);
    i_knob.press(30);
    chk("locked", disp_menu, 1'b0);
    axr(`FPM_ADDR_SETTINGS);
    chk("addon", {d[6:4], field_pct}, 10'h0);
    axw(`FPM_ADDR_CTRL, 32'h1);
    repeat (2) @(posedge aclk);
    chk("standby", disp_lock_msg, 1'b0);
    axw(`FPM_ADDR_CTRL, 32'h0);
    final_report();
  end
endmodule
